//--- gap_regs.vh
// Register map, field positions, defaults, ranges and timing for the alternator protection
`ifndef GAP_REGS_VH
`define GAP_REGS_VH

`define GAP_ADDR_W        8
`define GAP_OFF_CTRL      8'h00
`define GAP_OFF_VTHR      8'h04
`define GAP_OFF_VDLY      8'h08
`define GAP_OFF_FTHR      8'h0c
`define GAP_OFF_OFDLY     8'h10
`define GAP_OFF_UFDLY     8'h14
`define GAP_OFF_CDLY      8'h18
`define GAP_OFF_STATUS    8'h1c
`define GAP_OFF_INTSTAT   8'h20
`define GAP_OFF_INTMASK   8'h24

`define GAP_CTRL_LINK     0
`define GAP_CTRL_SENDER   1
`define GAP_CTRL_POLHI    2
`define GAP_CTRL_WIRE3    3
`define GAP_CTRL_FRST     4

`define GAP_INT_SHUT      0
`define GAP_INT_CWARN     1
`define GAP_INT_OIL       2
`define GAP_INT_W         3

`define GAP_HV_THR_DEF    8'h6e
`define GAP_HV_THR_MIN    8'h69
`define GAP_HV_THR_MAX    8'h7d
`define GAP_HV_DLY_DEF    8'h0a
`define GAP_HV_DLY_MIN    8'h01
`define GAP_HV_DLY_MAX    8'h0a
`define GAP_LV_THR_DEF    8'h55
`define GAP_LV_THR_MIN    8'h32
`define GAP_LV_THR_MAX    8'h5f
`define GAP_LV_DLY_DEF    8'h0a
`define GAP_LV_DLY_MIN    8'h02
`define GAP_LV_DLY_MAX    8'h14
`define GAP_FM_DEF        8'h06
`define GAP_FM_MIN        8'h02
`define GAP_FM_MAX        8'h0a
`define GAP_OF_DLY_DEF    11'h44c
`define GAP_OF_DLY_MIN    11'h064
`define GAP_UF_DLY_MIN    11'h1f4
`define GAP_HC_DLY_MAX    11'h7d0
`define GAP_CUR_DLY_DEF   8'h0a
`define GAP_CUR_DLY_MIN   8'h02
`define GAP_CUR_DLY_MAX   8'h3c

`define GAP_CODE_HV       16'h05a6
`define GAP_CODE_LV       16'h05a7
`define GAP_CODE_UF       16'h05a8
`define GAP_CODE_OF       16'h05a9
`define GAP_CODE_CUR      16'h05c0
`define GAP_CODE_NONE     16'h0000

`define GAP_NOM_HZ        8'h3c
`define GAP_CLK_HZ        25000000
`define GAP_TBASE_S       1

`endif

//--- gap_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gap_sync (
    input  wire sys_clk,
    input  wire rst_n,
    input  wire ce,
    input  wire din,
    output reg  dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    // First stage feeds only the second; a level counts once stages two and three agree
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout   <= 1'b0;
        end else if (ce) begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg)
                dout <= s3_reg;
        end
    end
endmodule // gap_sync

//--- gap_fault_timer.v
// Persistence timer: expires after the condition holds for limit ticks
`timescale 1ns/1ps
module gap_fault_timer #(
    parameter W = 8
) (
    input  wire         sys_clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         cond,
    input  wire         tick,
    input  wire [W-1:0] limit,
    output reg          expired
);
    reg [W-1:0] cnt_reg;

    // Any gap in the condition restarts the count from zero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
            expired <= 1'b0;
        end else if (ce) begin
            if (!cond)
                cnt_reg <= {W{1'b0}};
            else if (tick && (cnt_reg < limit))
                cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            expired <= cond && (cnt_reg >= limit);
        end
    end
endmodule // gap_fault_timer

//--- gap_protect.v
// Alternator protection: thresholds, delay timers, shutdown latch, oil sensor setup
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "gap_regs.vh"

module gap_protect #(
    parameter [24:0] SEC_CYCLES    = `GAP_TBASE_S * `GAP_CLK_HZ,
    parameter [7:0]  NOM_HZ        = `GAP_NOM_HZ,
    parameter [15:0] CUR_WARN_CODE = `GAP_CODE_NONE
) (
    input  wire                   sys_clk,
    input  wire                   rst_n,
    input  wire                   ce,
    input  wire [`GAP_ADDR_W-1:0] addr,
    input  wire [31:0]            wr_data,
    input  wire                   wr_en,
    input  wire                   rd_en,
    output reg  [31:0]            rd_data,
    input  wire [7:0]             volt_pct,
    input  wire [7:0]             freq_hz,
    input  wire                   line_zc_pin,
    input  wire                   cur_high_pin,
    input  wire                   cur_warn_pin,
    input  wire                   oil_switch_pin,
    input  wire                   fault_reset_pin,
    output reg                    engine_shutdown,
    output reg  [15:0]            fault_code,
    output reg  [15:0]            display_code,
    output reg                    oil_low,
    output reg                    oil_sender_sel,
    output reg                    oil_sender_3wire,
    output reg                    irq
);
    // Configuration registers
    reg                   link_en_reg;
    reg                   sender_reg;
    reg                   polhi_reg;
    reg                   wire3_reg;
    reg [7:0]             hv_thr_reg;
    reg [7:0]             lv_thr_reg;
    reg [7:0]             hv_dly_reg;
    reg [7:0]             lv_dly_reg;
    reg [7:0]             of_m_reg;
    reg [7:0]             uf_m_reg;
    reg [10:0]            of_dly_reg;
    reg [10:0]            uf_dly_reg;
    reg [7:0]             cur_dly_reg;
    reg [`GAP_INT_W-1:0]  int_stat_reg;
    reg [`GAP_INT_W-1:0]  int_mask_reg;
    reg                   frst_reg;
    // Time base and edge tracking
    reg [24:0]            sec_cnt_reg;
    reg                   sec_tick_reg;
    reg                   zc_prev_reg;
    reg                   cwarn_prev_reg;
    reg                   oil_prev_reg;
    reg [31:0]            rd_next;
    reg [15:0]            code_next;

    wire                  zc_s;
    wire                  cur_high_s;
    wire                  cur_warn_s;
    wire                  oil_s;
    wire                  frst_s;
    wire                  hc_tick;
    wire                  hv_cond;
    wire                  lv_cond;
    wire                  of_cond;
    wire                  uf_cond;
    wire                  hv_exp;
    wire                  lv_exp;
    wire                  of_exp;
    wire                  uf_exp;
    wire                  cur_exp;
    wire                  any_exp;
    wire                  oil_act;
    wire                  fault_clear;
    wire [8:0]            of_lim;
    wire [8:0]            uf_lim;
    wire [`GAP_INT_W-1:0] int_ev;

    // Keep a written value inside its allowed range
    function [10:0] clamp;
        input [10:0] v;
        input [10:0] lo;
        input [10:0] hi;
        begin
            clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction
    // Same clamp at the width of the 8-bit fields, so no result bit is cut
    function [7:0] clamp8;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // Pins from the outside world
    gap_sync u_sync_zc (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .din(line_zc_pin),
        .dout(zc_s));
    gap_sync u_sync_ch (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .din(cur_high_pin),
        .dout(cur_high_s));
    gap_sync u_sync_cw (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .din(cur_warn_pin),
        .dout(cur_warn_s));
    gap_sync u_sync_oil (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .din(oil_switch_pin),
        .dout(oil_s));
    gap_sync u_sync_fr (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .din(fault_reset_pin),
        .dout(frst_s));

    // Each edge of the zero-cross signal is one line half cycle
    assign hc_tick = zc_s ^ zc_prev_reg;

    // Fault conditions; frequency limits widened to avoid wrap
    assign hv_cond = volt_pct > hv_thr_reg;
    assign lv_cond = volt_pct < lv_thr_reg;
    assign of_lim  = {1'b0, NOM_HZ} + {1'b0, of_m_reg};
    assign uf_lim  = {1'b0, NOM_HZ} - {1'b0, uf_m_reg};
    assign of_cond = {1'b0, freq_hz} > of_lim;
    assign uf_cond = ({1'b0, freq_hz} < uf_lim) && !uf_lim[8];

    // Second-based delays
    gap_fault_timer #(.W(8)) u_tmr_hv (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .cond(hv_cond), .tick(sec_tick_reg), .limit(hv_dly_reg), .expired(hv_exp));
    gap_fault_timer #(.W(8)) u_tmr_lv (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .cond(lv_cond), .tick(sec_tick_reg), .limit(lv_dly_reg), .expired(lv_exp));
    gap_fault_timer #(.W(8)) u_tmr_cur (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .cond(cur_high_s), .tick(sec_tick_reg), .limit(cur_dly_reg),
        .expired(cur_exp));
    // Half-cycle delays
    gap_fault_timer #(.W(11)) u_tmr_of (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .cond(of_cond), .tick(hc_tick), .limit(of_dly_reg), .expired(of_exp));
    gap_fault_timer #(.W(11)) u_tmr_uf (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .cond(uf_cond), .tick(hc_tick), .limit(uf_dly_reg), .expired(uf_exp));

    assign any_exp     = hv_exp | lv_exp | of_exp | uf_exp | cur_exp;
    assign fault_clear = frst_s | frst_reg;
    // Switch reads active per polarity; a sender has no switch level
    assign oil_act     = !link_en_reg && !sender_reg && (polhi_reg ? oil_s : !oil_s);
    assign int_ev      = {oil_act & !oil_prev_reg,
                          cur_warn_s & !cwarn_prev_reg,
                          any_exp & !engine_shutdown};

    // Priority among faults expiring together: current first, then voltage, then frequency
    always @* begin
        if (cur_exp)
            code_next = `GAP_CODE_CUR;
        else if (hv_exp)
            code_next = `GAP_CODE_HV;
        else if (lv_exp)
            code_next = `GAP_CODE_LV;
        else if (of_exp)
            code_next = `GAP_CODE_OF;
        else
            code_next = `GAP_CODE_UF;
    end

    // One-second time base; a long count, shortened by parameter in simulation
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_reg  <= 25'h0000000;
            sec_tick_reg <= 1'b0;
        end else if (ce) begin
            sec_tick_reg <= (sec_cnt_reg == SEC_CYCLES - 25'h0000001);
            if (sec_cnt_reg == SEC_CYCLES - 25'h0000001)
                sec_cnt_reg <= 25'h0000000;
            else
                sec_cnt_reg <= sec_cnt_reg + 25'h0000001;
        end
    end

    // Register writes; every threshold, margin and delay field is clamped on entry; each field resets to its default
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_en_reg  <= 1'b0;
            sender_reg   <= 1'b0;
            polhi_reg    <= 1'b0;
            wire3_reg    <= 1'b0;
            hv_thr_reg   <= `GAP_HV_THR_DEF;
            lv_thr_reg   <= `GAP_LV_THR_DEF;
            hv_dly_reg   <= `GAP_HV_DLY_DEF;
            lv_dly_reg   <= `GAP_LV_DLY_DEF;
            of_m_reg     <= `GAP_FM_DEF;
            uf_m_reg     <= `GAP_FM_DEF;
            of_dly_reg   <= `GAP_OF_DLY_DEF;
            uf_dly_reg   <= `GAP_OF_DLY_DEF;
            cur_dly_reg  <= `GAP_CUR_DLY_DEF;
            int_mask_reg <= {`GAP_INT_W{1'b0}};
            frst_reg     <= 1'b0;
        end else if (ce) begin
            frst_reg <= wr_en && (addr == `GAP_OFF_CTRL) && wr_data[`GAP_CTRL_FRST];
            if (wr_en) begin
                case (addr)
                    `GAP_OFF_CTRL: begin
                        link_en_reg <= wr_data[`GAP_CTRL_LINK];
                        // Oil settings frozen while the controller link is on
                        if (!link_en_reg) begin
                            sender_reg <= wr_data[`GAP_CTRL_SENDER];
                            polhi_reg  <= wr_data[`GAP_CTRL_POLHI];
                            wire3_reg  <= wr_data[`GAP_CTRL_WIRE3];
                        end
                    end
                    `GAP_OFF_VTHR: begin
                        hv_thr_reg <= clamp8(wr_data[7:0], `GAP_HV_THR_MIN, `GAP_HV_THR_MAX);
                        lv_thr_reg <= clamp8(wr_data[15:8], `GAP_LV_THR_MIN, `GAP_LV_THR_MAX);
                    end
                    `GAP_OFF_VDLY: begin
                        hv_dly_reg <= clamp8(wr_data[7:0], `GAP_HV_DLY_MIN, `GAP_HV_DLY_MAX);
                        lv_dly_reg <= clamp8(wr_data[15:8], `GAP_LV_DLY_MIN, `GAP_LV_DLY_MAX);
                    end
                    `GAP_OFF_FTHR: begin
                        of_m_reg <= clamp8(wr_data[7:0], `GAP_FM_MIN, `GAP_FM_MAX);
                        uf_m_reg <= clamp8(wr_data[15:8], `GAP_FM_MIN, `GAP_FM_MAX);
                    end
                    `GAP_OFF_OFDLY:
                        of_dly_reg <= clamp(wr_data[10:0], `GAP_OF_DLY_MIN, `GAP_HC_DLY_MAX);
                    `GAP_OFF_UFDLY:
                        uf_dly_reg <= clamp(wr_data[10:0], `GAP_UF_DLY_MIN, `GAP_HC_DLY_MAX);
                    `GAP_OFF_CDLY:
                        cur_dly_reg <= clamp8(wr_data[7:0], `GAP_CUR_DLY_MIN, `GAP_CUR_DLY_MAX);
                    `GAP_OFF_INTMASK:
                        int_mask_reg <= wr_data[`GAP_INT_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Interrupt status: a new event wins over a write-one clear in the same cycle
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_reg   <= {`GAP_INT_W{1'b0}};
            cwarn_prev_reg <= 1'b0;
            oil_prev_reg   <= 1'b0;
            zc_prev_reg    <= 1'b0;
            irq            <= 1'b0;
        end else if (ce) begin
            cwarn_prev_reg <= cur_warn_s;
            oil_prev_reg   <= oil_act;
            zc_prev_reg    <= zc_s;
            if (wr_en && addr == `GAP_OFF_INTSTAT)
                int_stat_reg <= (int_stat_reg & ~wr_data[`GAP_INT_W-1:0]) | int_ev;
            else
                int_stat_reg <= int_stat_reg | int_ev;
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // Shutdown latch: first expiry sets it; only a fault reset releases it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            engine_shutdown <= 1'b0;
            fault_code      <= `GAP_CODE_NONE;
        end else if (ce) begin
            if (fault_clear) begin
                engine_shutdown <= 1'b0;
                fault_code      <= `GAP_CODE_NONE;
            end else if (any_exp && !engine_shutdown) begin
                engine_shutdown <= 1'b1;
                fault_code      <= code_next;
            end
        end
    end

    // Display and oil outputs; a latched shutdown masks the current warning
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            display_code     <= `GAP_CODE_NONE;
            oil_low          <= 1'b0;
            oil_sender_sel   <= 1'b0;
            oil_sender_3wire <= 1'b0;
        end else if (ce) begin
            if (engine_shutdown)
                display_code <= fault_code;
            else if (cur_warn_s)
                display_code <= CUR_WARN_CODE;
            else
                display_code <= `GAP_CODE_NONE;
            oil_low          <= oil_act;
            oil_sender_sel   <= !link_en_reg && sender_reg;
            oil_sender_3wire <= !link_en_reg && sender_reg && wire3_reg;
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rd_next = 32'h00000000;
        case (addr)
            `GAP_OFF_CTRL:    rd_next = {28'h0000000, wire3_reg, polhi_reg, sender_reg,
                                         link_en_reg};
            `GAP_OFF_VTHR:    rd_next = {16'h0000, lv_thr_reg, hv_thr_reg};
            `GAP_OFF_VDLY:    rd_next = {16'h0000, lv_dly_reg, hv_dly_reg};
            `GAP_OFF_FTHR:    rd_next = {16'h0000, uf_m_reg, of_m_reg};
            `GAP_OFF_OFDLY:   rd_next = {21'h000000, of_dly_reg};
            `GAP_OFF_UFDLY:   rd_next = {21'h000000, uf_dly_reg};
            `GAP_OFF_CDLY:    rd_next = {24'h000000, cur_dly_reg};
            `GAP_OFF_STATUS:  rd_next = {9'h000, oil_act, cur_warn_s, cur_high_s, uf_cond,
                                         of_cond, lv_cond, hv_cond, fault_code};
            `GAP_OFF_INTSTAT: rd_next = {29'h00000000, int_stat_reg};
            `GAP_OFF_INTMASK: rd_next = {29'h00000000, int_mask_reg};
            default:          rd_next = 32'h00000000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            rd_data <= 32'h00000000;
        else if (ce)
            rd_data <= rd_en ? rd_next : 32'h00000000;
    end
endmodule // gap_protect

//--- gap_protect_chk.sv
// Port checker for the alternator protection block
`timescale 1ns/1ps
`include "gap_regs.vh"
module gap_protect_chk #(
    parameter [7:0] NOM_HZ = 8'h3c
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic [7:0]  volt_pct,
    input wire logic [7:0]  freq_hz,
    input wire logic        fault_reset_pin,
    input wire logic        engine_shutdown,
    input wire logic [15:0] fault_code,
    input wire logic [15:0] display_code,
    input wire logic        oil_low,
    input wire logic        oil_sender_sel
);
    logic [3:0] since_rst_reg;
    wire        frst_wr = ce && wr_en && addr == `GAP_OFF_CTRL && wr_data[`GAP_CTRL_FRST];
    // Age of the last reset request; saturates so a long run never wraps it
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) since_rst_reg <= 4'hf;
        else if (fault_reset_pin || frst_wr) since_rst_reg <= 4'h0;
        else if (since_rst_reg != 4'hf) since_rst_reg <= since_rst_reg + 4'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_latched; engine_shutdown; endsequence
    sequence s_reset_req; frst_wr; endsequence
    chk_shut_hold: assert property ($fell(engine_shutdown) |-> since_rst_reg < 4'h8)
        else $error("shutdown dropped without reset");
    chk_code_stable: assert property (
        s_latched ##1 s_latched |-> $stable(fault_code))
        else $error("latched code changed");
    chk_code_pair: assert property (engine_shutdown == (fault_code != 16'h0))
        else $error("code and shutdown disagree");
    chk_frst_clear: assert property (
        s_latched ##0 s_reset_req |-> ##[1:2] !engine_shutdown)
        else $error("fault reset ignored");
    chk_disp_follow: assert property (
        $past(engine_shutdown) |-> display_code == $past(fault_code))
        else $error("display not showing shutdown");
    chk_hv_cause: assert property (
        $rose(engine_shutdown) && fault_code == `GAP_CODE_HV
        |-> $past(volt_pct, 2) > `GAP_HV_THR_MIN)
        else $error("high voltage trip without cause");
    chk_lv_cause: assert property (
        $rose(engine_shutdown) && fault_code == `GAP_CODE_LV
        |-> $past(volt_pct, 2) < `GAP_LV_THR_MAX)
        else $error("low voltage trip without cause");
    chk_of_cause: assert property (
        $rose(engine_shutdown) && fault_code == `GAP_CODE_OF
        |-> $past(freq_hz, 2) > NOM_HZ + 8'h02)
        else $error("overfrequency trip without cause");
    chk_uf_cause: assert property (
        $rose(engine_shutdown) && fault_code == `GAP_CODE_UF
        |-> $past(freq_hz, 2) < NOM_HZ - 8'h02)
        else $error("underfrequency trip without cause");
    chk_oil_excl: assert property (oil_low |-> !oil_sender_sel)
        else $error("switch flag while sender chosen");
endmodule // gap_protect_chk

//--- gap_alt_model.sv
// Alternator sense model: free-running zero-cross square wave
`timescale 1ns/1ps
module gap_alt_model #(
    parameter HALF = 4
) (
    input  wire logic sys_clk,
    output logic      line_zc_pin
);
    int cnt_reg = 0;
    initial line_zc_pin = 1'b0;
    // Each edge is one line half cycle; slow enough for the pin synchroniser
    always @(posedge sys_clk) begin
        cnt_reg <= (cnt_reg == HALF - 1) ? 0 : cnt_reg + 1;
        if (cnt_reg == HALF - 1) line_zc_pin <= ~line_zc_pin;
    end
endmodule // gap_alt_model

//--- testbench.sv
// Self-checking bench for the alternator protection block
`timescale 1ns/1ps
`include "gap_regs.vh"
module testbench;
    logic        sys_clk, rst_n, ce, wr_en, rd_en, line_zc_pin, irq;
    logic        cur_high_pin, cur_warn_pin, oil_switch_pin, fault_reset_pin;
    logic        engine_shutdown, oil_low, oil_sender_sel, oil_sender_3wire;
    logic [7:0]  addr, volt_pct, freq_hz;
    logic [31:0] wr_data, rd_data;
    logic [15:0] fault_code, display_code;
    int          failures, comparisons;

    gap_protect #(.SEC_CYCLES(25'h000000a)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .volt_pct(volt_pct), .freq_hz(freq_hz), .line_zc_pin(line_zc_pin),
        .cur_high_pin(cur_high_pin), .cur_warn_pin(cur_warn_pin),
        .oil_switch_pin(oil_switch_pin), .fault_reset_pin(fault_reset_pin),
        .engine_shutdown(engine_shutdown), .fault_code(fault_code),
        .display_code(display_code), .oil_low(oil_low), .oil_sender_sel(oil_sender_sel),
        .oil_sender_3wire(oil_sender_3wire), .irq(irq));
    gap_alt_model #(.HALF(4)) alt_u (.sys_clk(sys_clk), .line_zc_pin(line_zc_pin));

    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Bus tasks leave one idle cycle so no strobe is driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_en <= 1'b1; addr <= a; wr_data <= d;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_en <= 1'b1; addr <= a;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
        @(posedge sys_clk);
    endtask
    task automatic wait_shut(input int lim);
        int n;
        n = 0;
        while (engine_shutdown !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (engine_shutdown !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished, failures so far %0d", name, failures);
    endtask

    logic [7:0]  ra[6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] rdef[6] = '{32'h556e, 32'h0a0a, 32'h0606, 32'h44c, 32'h44c, 32'h0a};
    logic [31:0] rclp[6] = '{32'h327d, 32'h140a, 32'h020a, 32'h7d0, 32'h1f4, 32'h3c};
    logic [31:0] rwrk[6] = '{32'h556e, 32'h0203, 32'h0606, 32'h064, 32'h1f4, 32'h02};
    logic [7:0]  fv[4] = '{8'h50, 8'h64, 8'h64, 8'h64};
    logic [7:0]  ff[4] = '{8'h3c, 8'h43, 8'h35, 8'h3c};
    logic [15:0] fc[4] = '{16'h05a7, 16'h05a9, 16'h05a8, 16'h05c0};
    int          fl[4] = '{40, 600, 2500, 40};

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0; ce = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h0; wr_data = 32'h0;
        volt_pct = 8'h64; freq_hz = 8'h3c; cur_high_pin = 1'b0; cur_warn_pin = 1'b0;
        oil_switch_pin = 1'b0; fault_reset_pin = 1'b0; failures = 0; comparisons = 0;
        idle(3);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // Defaults, clamping at both ends, unmapped read
        for (int i = 0; i < 6; i++) rd(ra[i], rdef[i]);
        rd(8'h30, 32'h0);
        rd(8'h00, 32'h0);
        for (int i = 0; i < 6; i++) wr(ra[i], i[0] ? 32'h0000fff0 : 32'hffff00ff);
        for (int i = 0; i < 6; i++) rd(ra[i], rclp[i]);
        for (int i = 0; i < 6; i++) wr(ra[i], rwrk[i]);
        // A write while the clock enable is low must leave the setting alone
        ce <= 1'b0;
        wr(8'h18, 32'h5);
        ce <= 1'b1;
        rd(8'h18, 32'h02);
        chk(oil_low, 1'b1);
        done("settings");
        // Oil sensor configuration and the link lock
        wr(8'h00, 32'h4);
        idle(6);
        chk(oil_low, 1'b0);
        oil_switch_pin <= 1'b1;
        idle(6);
        chk(oil_low, 1'b1);
        wr(8'h00, 32'h2);
        idle(1);
        chk({oil_sender_sel, oil_sender_3wire, oil_low}, 3'b100);
        wr(8'h00, 32'ha);
        idle(1);
        chk({oil_sender_sel, oil_sender_3wire}, 2'b11);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h7);
        rd(8'h00, 32'h1);
        chk(oil_sender_sel, 1'b0);
        wr(8'h00, 32'h0);
        done("oil");
        // High voltage with an interrupted first attempt
        wr(8'h20, 32'h7);
        wr(8'h24, 32'h1);
        volt_pct <= 8'h82;
        idle(15);
        volt_pct <= 8'h64;
        idle(2);
        volt_pct <= 8'h82;
        idle(15);
        chk(engine_shutdown, 1'b0);
        wait_shut(40);
        chk(fault_code, 16'h05a6);
        rd(8'h1c, 32'h000105a6);
        idle(2);
        chk(display_code, 16'h05a6);
        chk(irq, 1'b1);
        rd(8'h20, 32'h1);
        volt_pct <= 8'h64;
        idle(10);
        chk(engine_shutdown, 1'b1);
        wr(8'h00, 32'h10);
        idle(1);
        chk({engine_shutdown, fault_code}, 17'h0);
        wr(8'h20, 32'h1);
        idle(2);
        chk(irq, 1'b0);
        wr(8'h24, 32'h0);
        done("high_voltage");
        // Remaining faults, each cleared by the reset pin
        for (int i = 0; i < 4; i++) begin
            volt_pct <= fv[i]; freq_hz <= ff[i];
            cur_high_pin <= (i == 3); cur_warn_pin <= (i == 3);
            idle(fl[i] / 4);
            chk(engine_shutdown, 1'b0);
            wait_shut(fl[i]);
            idle(2);
            chk({fault_code, display_code}, {fc[i], fc[i]});
            chk(irq, 1'b0);
            volt_pct <= 8'h64; freq_hz <= 8'h3c; cur_high_pin <= 1'b0; cur_warn_pin <= 1'b0;
            fault_reset_pin <= 1'b1;
            idle(6);
            fault_reset_pin <= 1'b0;
            idle(6);
            chk(engine_shutdown, 1'b0);
        end
        done("faults");
        summarize();
    end
endmodule // testbench

bind gap_protect gap_protect_chk #(.NOM_HZ(NOM_HZ)) chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .volt_pct(volt_pct),
    .freq_hz(freq_hz), .fault_reset_pin(fault_reset_pin), .engine_shutdown(engine_shutdown),
    .fault_code(fault_code), .display_code(display_code), .oil_low(oil_low),
    .oil_sender_sel(oil_sender_sel));
